// file: shared/caption_pkg.sv
// constants, types and register map for the caption capture block
package caption_pkg;

  // clock and signalling rates
  localparam int CLK_FREQ_KHZ     = 125000;
  localparam int CC_BIT_RATE_KHZ  = 503;
  localparam int RUNIN_RATE_KHZ   = 1006;
  localparam int CC_BIT_CYC       = CLK_FREQ_KHZ / CC_BIT_RATE_KHZ;
  localparam int RUNIN_CYC        = CLK_FREQ_KHZ / RUNIN_RATE_KHZ;
  localparam int RUNIN_TOL_CYC    = RUNIN_CYC / 4;
  localparam int LINE_BIT_PERIODS = 25;

  // packet shape
  localparam int RUNIN_BITS       = 14;
  localparam int RUNIN_EDGES      = RUNIN_BITS / 2;
  localparam int FRAMING_BITS     = 2;
  localparam int PAYLOAD_BITS     = 16;
  localparam int SAMPLE_BITS      = FRAMING_BITS + PAYLOAD_BITS;
  // first framing bit low, second high
  localparam logic [1:0] FRAMING_CODE = 2'b10;
  localparam logic [9:0] CAPTION_LINE = 10'h015;

  // register indices
  localparam logic [7:0] IDX_GENERAL_STATUS = 8'h00;
  localparam logic [7:0] IDX_CAPTION_DATA   = 8'h1a;
  localparam logic [7:0] IDX_DECODE_CONTROL = 8'h1b;

  // caption_fifo_status fields
  localparam int STS_NOT_EMPTY  = 0;
  localparam int STS_OVERFLOW   = 1;
  localparam int STS_PARITY_ERR = 2;
  localparam int STS_BYTE_HALF  = 3;
  localparam int STS_SERVICE    = 4;
  localparam int STS_HALF_FULL  = 5;
  localparam int STS_IRQ_EN     = 7;
  // general_status and caption_decode_control fields
  localparam int GEN_CAPTION_VALID = 0;
  localparam int CTL_CC_EN         = 0;
  localparam int CTL_EDS_EN        = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic       IRQ_EN_RESET  = 1'b0;

  localparam int FIFO_DEPTH = 16;

  // one stored entry: bit 9 service, bit 8 byte half, 7:0 data
  typedef struct packed {
    logic       parity_err;
    logic       service_type_tag;
    logic       byte_half_tag;
    logic [7:0] data;
  } caption_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RUNIN   = 3'b001,
    ST_SAMPLE  = 3'b011,
    ST_PUSH_LO = 3'b010,
    ST_PUSH_HI = 3'b110
  } slicer_state_t;

endpackage

// file: rtl/skid_buffer.sv
// two-entry valid/ready buffer between slicer and caption fifo
`timescale 1ns/100ps
module skid_buffer
#(
  parameter int WIDTH = 11
)
(
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("skid_buffer WIDTH must be positive");
    end
  endgenerate

  logic [WIDTH-1:0] slot_r [2];
  logic             wr_sel_r;
  logic             rd_sel_r;
  logic [1:0]       fill_r;

  wire do_in  = in_valid_in && in_ready_out;
  wire do_out = out_valid_out && out_ready_in;

  assign in_ready_out  = (fill_r != 2'd2);
  assign out_valid_out = (fill_r != 2'd0);
  assign out_data_out  = slot_r[rd_sel_r];

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_sel_r <= 1'b0;
      rd_sel_r <= 1'b0;
      fill_r   <= 2'd0;
    end
    else
    begin
      if (do_in)
        wr_sel_r <= ~wr_sel_r;
      if (do_out)
        rd_sel_r <= ~rd_sel_r;
      fill_r <= fill_r + {1'b0, do_in} - {1'b0, do_out};
    end
  end

  // storage needs no reset; valid comes from fill_r
  always_ff @(posedge sys_clk_in)
  begin
    if (do_in)
      slot_r[wr_sel_r] <= in_data_in;
  end

endmodule

// file: rtl/caption_capture_fifo.sv
// caption and data-service slicer with tagged 16-entry capture fifo
//
// Overview of operation
// - Caption bytes are sought only on line 21 of the odd field.
// - Data-service bytes sought on the even field line, independently of captions.
// - A caption line is 25 bit periods at 0.503 MHz.
// - Header is 14 run-in bits at 1.006 MHz then two framing bits.
// - Payload is sixteen bits: two bytes of seven bits plus odd parity.
// - Slicing uses the separated luma input only.
// - Control register at index 0x1B enables caption and data-service decoding.
// - Search run-in, lock to it, shift bits in, then move to fifo.
// - Buffer holds 16 entries of 11 bits, eight lines of two bytes.
// - Low byte written first, then high byte, each only when not full.
// - Bit 8 tags low/high byte, bit 9 tags caption/data-service origin.
// - Odd parity result of each byte shows as parity-error status bit.
// - Empty status bit reads low when no data, high once stored.
// - Half full drives enabled interrupt and a general status mirror bit.
// - Oldest entry shown at once; each data read advances to next.
// - Byte arriving when full is discarded and sets the overflow flag.
// - Data read with no coincident decoder write clears overflow.
// - Simultaneous host read and decoder write: the read is served first.
// - Read coinciding with write in overflow keeps overflow, drops the write.
`timescale 1ns/100ps
module caption_capture_fifo
  import caption_pkg::*;
#(
  parameter int           DEPTH       = FIFO_DEPTH,
  parameter logic [7:0]   SLICE_LEVEL = 8'h40
)
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // decoded video timing and luma
  input  wire logic [7:0] luma_in,
  input  wire logic       field_start_in,
  input  wire logic       field_odd_in,
  input  wire logic       line_start_in,
  // host register port
  input  wire logic [7:0] reg_index_in,
  input  wire logic       reg_rd_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  output logic      [7:0] caption_fifo_status_out,
  // interrupt
  output logic            caption_fifo_half_full_irq_out
);

  localparam int PTR_W = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH)
    begin : g_bad_depth
      $error("caption_capture_fifo DEPTH must be a power of two, at least 2");
    end
  endgenerate

  // odd parity holds when the xor of all eight bits is one
  function automatic logic parity_bad(input logic [7:0] b);
    parity_bad = ~(^b);
  endfunction

  // ---------------- host strobe synchronisers ----------------
  logic rd_meta_r;
  logic rd_sync_r;
  logic rd_prev_r;
  logic wr_meta_r;
  logic wr_sync_r;
  logic wr_prev_r;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_meta_r <= 1'b0;
      rd_sync_r <= 1'b0;
      rd_prev_r <= 1'b0;
      wr_meta_r <= 1'b0;
      wr_sync_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end
    else
    begin
      rd_meta_r <= reg_rd_in;
      rd_sync_r <= rd_meta_r;
      rd_prev_r <= rd_sync_r;
      wr_meta_r <= reg_wr_in;
      wr_sync_r <= wr_meta_r;
      wr_prev_r <= wr_sync_r;
    end
  end

  wire rd_pulse = rd_sync_r & ~rd_prev_r;
  wire wr_pulse = wr_sync_r & ~wr_prev_r;

  // ---------------- control registers ----------------
  logic [7:0] control_r;
  logic       irq_en_r;

  wire wr_control = wr_pulse && (reg_index_in == IDX_DECODE_CONTROL);
  wire wr_status  = wr_pulse && (reg_index_in == IDX_CAPTION_DATA);

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      control_r <= CONTROL_RESET;
      irq_en_r  <= IRQ_EN_RESET;
    end
    else
    begin
      if (wr_control)
        control_r <= reg_wdata_in;
      if (wr_status)
        irq_en_r <= reg_wdata_in[STS_IRQ_EN];
    end
  end

  // ---------------- line selection ----------------
  logic [9:0] line_cnt_r;
  logic       line_odd_r;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      line_cnt_r <= 10'h000;
      line_odd_r <= 1'b0;
    end
    else if (field_start_in)
    begin
      line_cnt_r <= 10'h000;
      line_odd_r <= field_odd_in;
    end
    else if (line_start_in && line_cnt_r != 10'h3ff)
      line_cnt_r <= line_cnt_r + 10'h001;
  end

  // odd field line 21 carries captions
  wire cc_line  = line_odd_r && control_r[CTL_CC_EN];
  wire eds_line = !line_odd_r && control_r[CTL_EDS_EN];
  wire line_hit = line_start_in && (line_cnt_r + 10'h001 == CAPTION_LINE)
                  && (cc_line || eds_line);

  // ---------------- slicer ----------------
  slicer_state_t            state_r;
  slicer_state_t            state_nxt;
  logic [15:0]              phase_r;
  logic [15:0]              line_age_r;
  logic [4:0]               count_r;
  logic [SAMPLE_BITS-1:0]   shift_r;
  logic                     service_r;
  logic                     sliced_r;

  wire sliced    = (luma_in > SLICE_LEVEL);
  wire rise      = sliced && !sliced_r;
  wire gap_ok    = (phase_r >= 16'(RUNIN_CYC - RUNIN_TOL_CYC))
                   && (phase_r <= 16'(RUNIN_CYC + RUNIN_TOL_CYC));
  wire sample_at = (phase_r == 16'h0000);
  // give up once the 25-period line has passed
  wire line_over = (line_age_r >= 16'(LINE_BIT_PERIODS * CC_BIT_CYC));
  wire [7:0] lo_byte = shift_r[FRAMING_BITS +: 8];
  wire [7:0] hi_byte = shift_r[FRAMING_BITS + 8 +: 8];

  caption_entry_t push_entry;
  logic           push_valid;
  logic           push_ready;

  // low byte first, then high byte
  assign push_valid = (state_r == ST_PUSH_LO) || (state_r == ST_PUSH_HI);
  assign push_entry.service_type_tag = service_r;
  assign push_entry.byte_half_tag    = (state_r == ST_PUSH_HI);
  assign push_entry.data             = (state_r == ST_PUSH_HI) ? hi_byte : lo_byte;
  assign push_entry.parity_err       = parity_bad(push_entry.data);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (line_hit)
          state_nxt = ST_RUNIN;
      ST_RUNIN:
        if (line_start_in || line_over)
          state_nxt = ST_IDLE;
        else if (rise && count_r != 5'd0 && !gap_ok)
          state_nxt = ST_IDLE;
        else if (rise && count_r == 5'(RUNIN_EDGES - 1))
          state_nxt = ST_SAMPLE;
      ST_SAMPLE:
        if (line_start_in || line_over)
          state_nxt = ST_IDLE;
        else if (sample_at && count_r == 5'(SAMPLE_BITS - 1))
          // last bit still shifting in, so framing sits one place up
          state_nxt = (shift_r[2:1] == FRAMING_CODE) ? ST_PUSH_LO : ST_IDLE;
      ST_PUSH_LO:
        if (push_ready)
          state_nxt = ST_PUSH_HI;
      ST_PUSH_HI:
        if (push_ready)
          state_nxt = ST_IDLE;
    endcase
  end

  // run-in edges then framing and payload sampling
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_r    <= ST_IDLE;
      phase_r    <= 16'h0000;
      line_age_r <= 16'h0000;
      count_r    <= 5'd0;
      shift_r    <= '0;
      service_r  <= 1'b0;
      sliced_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      sliced_r <= sliced;
      if (state_r == ST_IDLE)
      begin
        phase_r    <= 16'h0000;
        line_age_r <= 16'h0000;
        count_r    <= 5'd0;
        service_r  <= line_odd_r;
      end
      else
        line_age_r <= line_age_r + 16'h0001;
      if (state_r == ST_RUNIN)
      begin
        if (rise && count_r == 5'(RUNIN_EDGES - 1))
        begin
          // centre of first framing bit after the last run-in cycle
          phase_r <= 16'(RUNIN_CYC + CC_BIT_CYC / 2);
          count_r <= 5'd0;
        end
        else if (rise)
        begin
          phase_r <= 16'h0001;
          count_r <= count_r + 5'd1;
        end
        else
          phase_r <= phase_r + 16'h0001;
      end
      if (state_r == ST_SAMPLE)
      begin
        if (sample_at)
        begin
          shift_r <= {sliced, shift_r[SAMPLE_BITS-1:1]};
          phase_r <= 16'(CC_BIT_CYC - 1);
          count_r <= count_r + 5'd1;
        end
        else
          phase_r <= phase_r - 16'h0001;
      end
    end
  end

  // ---------------- two-entry buffer ----------------
  caption_entry_t buf_entry;
  logic           buf_valid;
  logic           buf_ready;

  skid_buffer #(
    .WIDTH         ($bits(caption_entry_t))
  ) u_skid (
    .sys_clk_in    (sys_clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_entry),
    .out_valid_out (buf_valid),
    .out_ready_in  (buf_ready),
    .out_data_out  (buf_entry)
  );

  // ---------------- capture fifo ----------------
  // sixteen tagged entries
  caption_entry_t   mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0]   count_fifo_r;
  logic             overflow_r;

  wire fifo_empty = (count_fifo_r == '0);
  wire fifo_full  = (count_fifo_r == (PTR_W+1)'(DEPTH));
  wire half_full  = (count_fifo_r >= (PTR_W+1)'(DEPTH / 2));
  // each data read advances the fifo
  wire pop        = rd_pulse && (reg_index_in == IDX_CAPTION_DATA) && !fifo_empty;
  // a coincident read outside overflow holds the write back one cycle
  assign buf_ready = !(pop && !overflow_r);
  wire fifo_write = buf_valid && !pop && !fifo_full;
  wire drop_full  = buf_valid && !pop && fifo_full;
  // read in overflow with a write: write lost, flag kept
  wire drop_ovf   = buf_valid && pop && overflow_r;
  // read with no coincident write frees space and clears
  wire ovf_clear  = pop && !buf_valid;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_r     <= '0;
      rd_ptr_r     <= '0;
      count_fifo_r <= '0;
      overflow_r   <= 1'b0;
    end
    else
    begin
      if (fifo_write)
        wr_ptr_r <= wr_ptr_r + PTR_W'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_r + PTR_W'(1);
      count_fifo_r <= count_fifo_r + {{PTR_W{1'b0}}, fifo_write}
                      - {{PTR_W{1'b0}}, pop};
      // set beats clear; drop_ovf keeps the flag as it is
      if (drop_full)
        overflow_r <= 1'b1;
      else if (ovf_clear && !drop_ovf)
        overflow_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (fifo_write)
      mem_r[wr_ptr_r] <= buf_entry;
  end

  // ---------------- register read and status ----------------
  caption_entry_t head;
  logic [7:0]     status_nxt;
  logic [7:0]     general_nxt;
  logic [7:0]     rdata_nxt;

  // oldest entry visible as soon as stored
  assign head = fifo_empty ? caption_entry_t'('0) : mem_r[rd_ptr_r];

  always_comb
  begin
    status_nxt                 = 8'h00;
    status_nxt[STS_NOT_EMPTY]  = !fifo_empty;
    status_nxt[STS_OVERFLOW]   = overflow_r;
    status_nxt[STS_PARITY_ERR] = head.parity_err;
    status_nxt[STS_BYTE_HALF]  = head.byte_half_tag;
    status_nxt[STS_SERVICE]    = head.service_type_tag;
    status_nxt[STS_HALF_FULL]  = half_full;
    status_nxt[STS_IRQ_EN]     = irq_en_r;
    // poll mirror of the half-full event
    general_nxt                    = 8'h00;
    general_nxt[GEN_CAPTION_VALID] = half_full;
  end

  assign rdata_nxt = (reg_index_in == IDX_GENERAL_STATUS) ? general_nxt :
                     (reg_index_in == IDX_CAPTION_DATA)   ? head.data   :
                     (reg_index_in == IDX_DECODE_CONTROL) ? control_r   : 8'h00;

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      reg_rdata_out                  <= 8'h00;
      caption_fifo_status_out        <= 8'h00;
      caption_fifo_half_full_irq_out <= 1'b0;
    end
    else
    begin
      reg_rdata_out                  <= rdata_nxt;
      caption_fifo_status_out        <= status_nxt;
      caption_fifo_half_full_irq_out <= half_full && irq_en_r;
    end
  end

endmodule

// file: tb/caption_capture_fifo_properties.sv
// port-level checks for the caption capture fifo
`timescale 1ns/100ps
module caption_capture_fifo_properties
  import caption_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  // watched inputs
  input  wire logic       line_start_in,
  input  wire logic [7:0] reg_index_in,
  input  wire logic       reg_rd_in,
  // watched outputs
  input  wire logic [7:0] reg_rdata_out,
  input  wire logic [7:0] caption_fifo_status_out,
  input  wire logic       caption_fifo_half_full_irq_out
);
  logic [15:0] rd_age_r;
  logic [15:0] ls_age_r;
  logic        rd_prev_r;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // saturating ages: pops and pushes must have a nearby cause
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_age_r  <= 16'hffff;
      ls_age_r  <= 16'hffff;
      rd_prev_r <= 1'b0;
    end
    else
    begin
      rd_prev_r <= reg_rd_in;
      rd_age_r  <= (reg_rd_in && !rd_prev_r) ? 16'h0000 : rd_age_r + {15'h0000, rd_age_r != 16'hffff};
      ls_age_r  <= line_start_in ? 16'h0000 : ls_age_r + {15'h0000, ls_age_r != 16'hffff};
    end
  end

  a_reset_clear: assert property ($rose(rst_b_in) |-> caption_fifo_status_out == 8'h00
    && !caption_fifo_half_full_irq_out) else $error("outputs not clear after reset");
  a_irq_gate: assert property (caption_fifo_half_full_irq_out ==
    (caption_fifo_status_out[STS_HALF_FULL] && caption_fifo_status_out[STS_IRQ_EN]))
    else $error("irq differs from half full and enable");
  a_gen_mirror: assert property (reg_index_in == IDX_GENERAL_STATUS && $stable(reg_index_in)
    |=> reg_rdata_out == {7'h00, caption_fifo_status_out[STS_HALF_FULL]})
    else $error("general status does not mirror half full");
  a_unmapped_zero: assert property (reg_index_in == 8'h55 && $stable(reg_index_in)
    |=> reg_rdata_out == 8'h00) else $error("unmapped index reads nonzero");
  a_half_not_empty: assert property (caption_fifo_status_out[STS_HALF_FULL]
    |-> caption_fifo_status_out[STS_NOT_EMPTY]) else $error("half full while empty");
  a_pop_needs_read: assert property ($fell(caption_fifo_status_out[STS_NOT_EMPTY])
    |-> rd_age_r < 16'h0008) else $error("fifo emptied without a read");
  a_half_drop_read: assert property ($fell(caption_fifo_status_out[STS_HALF_FULL])
    |-> rd_age_r < 16'h0008) else $error("half full dropped without a read");
  a_ovf_when_full: assert property ($rose(caption_fifo_status_out[STS_OVERFLOW])
    |-> caption_fifo_status_out[STS_HALF_FULL]) else $error("overflow below half full");
  a_ovf_clear_read: assert property ($fell(caption_fifo_status_out[STS_OVERFLOW])
    |-> rd_age_r < 16'h0008) else $error("overflow cleared without a read");
  a_push_in_line: assert property ($rose(caption_fifo_status_out[STS_NOT_EMPTY])
    |-> ls_age_r < 16'h1a00) else $error("entry stored outside a line");
endmodule

bind caption_capture_fifo caption_capture_fifo_properties #(.DEPTH(DEPTH))
  caption_capture_fifo_properties_i (
  .sys_clk_in                     (sys_clk_in),
  .rst_b_in                       (rst_b_in),
  .line_start_in                  (line_start_in),
  .reg_index_in                   (reg_index_in),
  .reg_rd_in                      (reg_rd_in),
  .reg_rdata_out                  (reg_rdata_out),
  .caption_fifo_status_out        (caption_fifo_status_out),
  .caption_fifo_half_full_irq_out (caption_fifo_half_full_irq_out)
);

// file: tb/caption_host_model.sv
// host controller model driving the register strobes
`timescale 1ns/100ps
module caption_host_model
(
  // clock
  input  wire logic       sys_clk_in,
  // register port
  output logic      [7:0] reg_index_out,
  output logic            reg_rd_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_wdata_out,
  input  wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_index_out = 8'h00;
    reg_rd_out    = 1'b0;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // answer lags the index by a clock, so wait before taking it
  task automatic peek_reg(input logic [7:0] idx, output logic [7:0] val);
    reg_index_out = idx;
    repeat (3) @(negedge sys_clk_in);
    val = reg_rdata_in;
  endtask

  // one strobe per data read, gap covers the sync delay
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
    peek_reg(idx, val);
    reg_rd_out = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    reg_rd_out = 1'b0;
    repeat (6) @(negedge sys_clk_in);
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
    reg_index_out = idx;
    reg_wdata_out = val;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    // released data no longer shows the written value
    reg_wdata_out = ~val;
  endtask
endmodule

// file: tb/caption_capture_fifo_tb.sv
// self-checking bench for the caption capture fifo
`timescale 1ns/100ps
module caption_capture_fifo_tb;
  import caption_pkg::*;
  localparam logic [7:0] LUMA_HI = 8'hc0;
  localparam logic [7:0] LUMA_LO = 8'h10;
  // negedges from a line call until the read whose pop meets the low byte push
  localparam int         RACE_WAIT = 5291;

  logic       sys_clk_in;
  logic       rst_b_in;
  logic [7:0] luma_in;
  logic       field_start_in;
  logic       field_odd_in;
  logic       line_start_in;
  wire  [7:0] reg_index;
  wire        reg_rd;
  wire        reg_wr;
  wire  [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] sts;
  logic       irq;
  int         error_cnt;
  int         cmp_count;
  int         cyc;

  caption_capture_fifo caption_capture_fifo_i (
    .sys_clk_in                     (sys_clk_in),
    .rst_b_in                       (rst_b_in),
    .luma_in                        (luma_in),
    .field_start_in                 (field_start_in),
    .field_odd_in                   (field_odd_in),
    .line_start_in                  (line_start_in),
    .reg_index_in                   (reg_index),
    .reg_rd_in                      (reg_rd),
    .reg_wr_in                      (reg_wr),
    .reg_wdata_in                   (reg_wdata),
    .reg_rdata_out                  (reg_rdata),
    .caption_fifo_status_out        (sts),
    .caption_fifo_half_full_irq_out (irq)
  );

  caption_host_model caption_host_model_i (
    .sys_clk_in    (sys_clk_in),
    .reg_index_out (reg_index),
    .reg_rd_out    (reg_rd),
    .reg_wr_out    (reg_wr),
    .reg_wdata_out (reg_wdata),
    .reg_rdata_in  (reg_rdata)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    caption_host_model_i.peek_reg(idx, v);
    chk("register", exp, v);
  endtask

  // head status ignores overflow, half full and irq enable bits
  task automatic pop_chk(input logic half, input logic svc, input logic [7:0] d);
    logic [7:0] v;
    chk("head status", {3'h0, svc, half, ~^d, 2'h1} & 8'h1d, sts & 8'h1d);
    caption_host_model_i.rd_reg(IDX_CAPTION_DATA, v);
    chk("head data", d, v);
  endtask

  // line 21 of a field: run-in, framing low then high, data lsb first
  task automatic drive_line(input logic odd, input logic [7:0] lo, input logic [7:0] hi);
    logic [17:0] bits;
    bits = {hi, lo, 2'h2};
    field_odd_in = odd;
    field_start_in = 1'b1;
    @(negedge sys_clk_in);
    field_start_in = 1'b0;
    repeat (21)
    begin
      @(negedge sys_clk_in);
      line_start_in = 1'b1;
      @(negedge sys_clk_in);
      line_start_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
    end
    repeat (7)
    begin
      luma_in = LUMA_HI;
      repeat (62) @(negedge sys_clk_in);
      luma_in = LUMA_LO;
      repeat (62) @(negedge sys_clk_in);
    end
    for (int i = 0; i < 18; i++)
    begin
      luma_in = bits[i] ? LUMA_HI : LUMA_LO;
      repeat (248) @(negedge sys_clk_in);
    end
    luma_in = LUMA_LO;
    repeat (20) @(negedge sys_clk_in);
  endtask

  task automatic t_reset();
    chk("status", 8'h00, sts);
    reg_chk(IDX_GENERAL_STATUS, 8'h00);
    reg_chk(IDX_DECODE_CONTROL, 8'h00);
    reg_chk(8'h55, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_caption();
    caption_host_model_i.wr_reg(IDX_DECODE_CONTROL, 8'h03);
    reg_chk(IDX_DECODE_CONTROL, 8'h03);
    drive_line(1'b1, 8'hc1, 8'h42);
    chk("status", 8'h11, sts);
    pop_chk(1'b0, 1'b1, 8'hc1);
    pop_chk(1'b1, 1'b1, 8'h42);
    chk("status", 8'h00, sts);
    $display("test caption done");
  endtask

  task automatic t_eds();
    drive_line(1'b0, 8'h80, 8'h83);
    pop_chk(1'b0, 1'b0, 8'h80);
    pop_chk(1'b1, 1'b0, 8'h83);
    caption_host_model_i.wr_reg(IDX_DECODE_CONTROL, 8'h02);
    drive_line(1'b1, 8'h41, 8'h41);
    chk("status", 8'h00, sts);
    $display("test data service done");
  endtask

  task automatic t_fill();
    caption_host_model_i.wr_reg(IDX_DECODE_CONTROL, 8'h01);
    caption_host_model_i.wr_reg(IDX_CAPTION_DATA, 8'h80);
    for (int i = 0; i < 4; i++)
      drive_line(1'b1, 8'h10 + 8'(i), 8'h20 + 8'(i));
    chk("half", 8'ha0, sts & 8'he0);
    chk("irq", 8'h01, {7'h00, irq});
    reg_chk(IDX_GENERAL_STATUS, 8'h01);
    caption_host_model_i.wr_reg(IDX_CAPTION_DATA, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
    caption_host_model_i.wr_reg(IDX_CAPTION_DATA, 8'h80);
    for (int i = 4; i < 9; i++)
      drive_line(1'b1, 8'h10 + 8'(i), 8'h20 + 8'(i));
    chk("overflow", 8'h02, sts & 8'h02);
    // read lands on the edge where line 9's low byte leaves the buffer
    fork
      drive_line(1'b1, 8'h19, 8'h29);
      begin
        repeat (RACE_WAIT) @(negedge sys_clk_in);
        pop_chk(1'b0, 1'b1, 8'h10);
      end
    join
    chk("overflow", 8'h02, sts & 8'h02);
    pop_chk(1'b1, 1'b1, 8'h20);
    chk("overflow", 8'h00, sts & 8'h02);
    for (int i = 1; i < 8; i++)
    begin
      pop_chk(1'b0, 1'b1, 8'h10 + 8'(i));
      chk("overflow", 8'h00, sts & 8'h02);
      pop_chk(1'b1, 1'b1, 8'h20 + 8'(i));
    end
    pop_chk(1'b1, 1'b1, 8'h29);
    chk("status", 8'h80, sts);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test fill done");
  endtask

  initial
  begin
    rst_b_in = 1'b0;
    luma_in = LUMA_LO;
    field_start_in = 1'b0;
    field_odd_in = 1'b0;
    line_start_in = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (12) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    t_reset();
    t_caption();
    t_eds();
    t_fill();
    wrap_up();
  end
endmodule
